// file: hdl/disp_bus_pkg.sv
package disp_bus_pkg;
    // Clock period in ns (20 MHz)
    localparam int CLK_NS = 50;
    // Write strobe timing, ns, least values
    localparam int WR_LOW_NS = 170;
    localparam int WR_HIGH_NS = 85;
    localparam int WR_SETUP_NS = 85;
    // Read strobe timing, ns, least values
    localparam int RD_LOW_NS = 300;
    localparam int RD_HIGH_NS = 300;
    localparam int RD_HOLD_NS = 150;
    // Display reset pulse width, ns (own choice)
    localparam int RST_LOW_NS = 10000;
    // Cycle counts, least times rounded up
    localparam int WR_LOW_CYC = (WR_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_HIGH_CYC = (WR_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_SETUP_CYC = (WR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_LOW_CYC = (RD_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_HIGH_CYC = (RD_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_HOLD_CYC = (RD_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;

    // Display-side pin bundle
    typedef struct packed {
        logic select_n;
        logic register_select;
        logic read_n;
        logic write_n;
        logic display_reset_n;
    } disp_ctrl_t;

    // User request
    typedef struct packed {
        logic is_read;
        logic register_select;
        logic [7:0] data;
    } disp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_RECOVER = 3'b100,
        ST_RESET = 3'b101
    } state_t;
endpackage

// file: hdl/display_parallel_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] All transfers use one 8-bit two-way bus; display drives it on reads only.
// [R2] Select held low for the whole access; high means no operation.
// [R3] Status read: select 0, register select 0, read 0, write 1.
// [R4] Index write: select 0, register select 0, read 1, write 0.
// [R5] Graphics RAM read: select 0, register select 1, read 0, write 1.
// [R6] Data write: select 0, register select 1, read 1, write 0.
// [R7] Register select low picks index/status, high picks RAM/register data.
// [R8] Each write pulses write strobe low while data is driven.
// [R9] Display reset driven low for a pulse to initialise the display.
// [R10] Each read pulses read strobe low and captures the bus byte.
// [R11] Bus drivers released before read strobe; driven only during writes.
module display_parallel_bus_master (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire disp_bus_pkg::disp_req_t req,
    input wire logic reset_req,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output var disp_bus_pkg::disp_ctrl_t ctrl,
    input wire logic [7:0] display_data_bus_in,
    output logic [7:0] display_data_bus_out,
    output logic display_data_bus_oe
);
    disp_bus_pkg::state_t state_r, state_nxt;
    logic [disp_bus_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    disp_bus_pkg::disp_req_t cur_r, cur_nxt;
    disp_bus_pkg::disp_ctrl_t ctrl_r, ctrl_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic boot_r, boot_nxt;

    localparam logic [7:0] C_WR_SETUP = 8'(disp_bus_pkg::WR_SETUP_CYC);
    localparam logic [7:0] C_WR_LOW = 8'(disp_bus_pkg::WR_LOW_CYC);
    localparam logic [7:0] C_WR_HIGH = 8'(disp_bus_pkg::WR_HIGH_CYC);
    localparam logic [7:0] C_RD_LOW = 8'(disp_bus_pkg::RD_LOW_CYC);
    localparam logic [7:0] C_RD_HIGH = 8'(disp_bus_pkg::RD_HIGH_CYC);
    localparam logic [7:0] C_RD_HOLD = 8'(disp_bus_pkg::RD_HOLD_CYC);
    localparam logic [7:0] C_RST_LOW = 8'(disp_bus_pkg::RST_LOW_CYC);

    // Accept only when idle and the reset pulse has finished
    assign req_ready = (state_r == disp_bus_pkg::ST_IDLE) && !boot_r
        && !reset_req;

    // Transfer sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cur_nxt = cur_r;
        ctrl_nxt = ctrl_r;
        oe_nxt = oe_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        boot_nxt = boot_r;
        unique case (state_r)
            disp_bus_pkg::ST_IDLE: begin
                ctrl_nxt.select_n = 1'b1; // No operation while idle [R2]
                ctrl_nxt.read_n = 1'b1;
                ctrl_nxt.write_n = 1'b1;
                oe_nxt = 1'b0;
                if (boot_r || reset_req) begin
                    ctrl_nxt.display_reset_n = 1'b0; // Init pulse [R9]
                    cnt_nxt = C_RST_LOW;
                    boot_nxt = 1'b0;
                    state_nxt = disp_bus_pkg::ST_RESET;
                end else if (req_valid) begin
                    cur_nxt = req;
                    ctrl_nxt.select_n = 1'b0; // Held low whole access [R2]
                    // Low: index/status, high: RAM/data [R7]
                    ctrl_nxt.register_select = req.register_select;
                    // Read leaves bus released before strobe [R11]
                    oe_nxt = !req.is_read; // [R1]
                    cnt_nxt = req.is_read ? 8'h01 : C_WR_SETUP;
                    state_nxt = disp_bus_pkg::ST_SETUP;
                end
            end
            disp_bus_pkg::ST_SETUP: begin
                if (cnt_r <= 8'h01) begin
                    if (cur_r.is_read) begin
                        ctrl_nxt.read_n = 1'b0; // Read strobe [R3] [R5] [R10]
                        cnt_nxt = C_RD_LOW;
                    end else begin
                        ctrl_nxt.write_n = 1'b0; // Write strobe [R4] [R6] [R8]
                        cnt_nxt = C_WR_LOW;
                    end
                    state_nxt = disp_bus_pkg::ST_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            disp_bus_pkg::ST_STROBE: begin
                if (cnt_r <= 8'h01) begin
                    ctrl_nxt.read_n = 1'b1;
                    ctrl_nxt.write_n = 1'b1;
                    if (cur_r.is_read) begin
                        // Sample at the rising read edge [R10]
                        rd_data_nxt = display_data_bus_in;
                        rd_valid_nxt = 1'b1;
                        cnt_nxt = C_RD_HOLD;
                    end else begin
                        cnt_nxt = 8'h01; // Data held past rising edge
                    end
                    state_nxt = disp_bus_pkg::ST_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            disp_bus_pkg::ST_HOLD: begin
                if (cnt_r <= 8'h01) begin
                    ctrl_nxt.select_n = 1'b1;
                    oe_nxt = 1'b0; // Drive only during writes [R11]
                    cnt_nxt = cur_r.is_read ? C_RD_HIGH : C_WR_HIGH;
                    state_nxt = disp_bus_pkg::ST_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            disp_bus_pkg::ST_RECOVER: begin
                // Strobe-high time before the next access
                if (cnt_r <= 8'h01) begin
                    state_nxt = disp_bus_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            disp_bus_pkg::ST_RESET: begin
                if (cnt_r <= 8'h01) begin
                    ctrl_nxt.display_reset_n = 1'b1; // [R9]
                    state_nxt = disp_bus_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = disp_bus_pkg::ST_IDLE;
            end
        endcase
    end

    // Registers; reset runs one display reset pulse after release
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= disp_bus_pkg::ST_IDLE;
            cnt_r <= 8'h00;
            cur_r <= '0;
            ctrl_r <= 5'h1F;
            oe_r <= 1'b0;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
            boot_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cur_r <= cur_nxt;
            ctrl_r <= ctrl_nxt;
            oe_r <= oe_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            boot_r <= boot_nxt;
        end
    end

    assign ctrl = ctrl_r;
    assign display_data_bus_oe = oe_r;
    assign display_data_bus_out = cur_r.data; // Stable from setup on
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;

    // Write low width counter for checks
    logic [7:0] wl_cnt_r;
    always_ff @(posedge clock) begin
        if (rst || ctrl_r.write_n) begin
            wl_cnt_r <= 8'h00;
        end else begin
            wl_cnt_r <= wl_cnt_r + 8'h01;
        end
    end

    a_strobe_needs_select: assert property (@(posedge clock) disable iff (rst)
        (!ctrl.read_n || !ctrl.write_n) |-> !ctrl.select_n) // [R2]
        else $error("strobe active with select high");
    a_no_drive_on_read: assert property (@(posedge clock) disable iff (rst)
        !ctrl.read_n |-> !display_data_bus_oe) // [R11]
        else $error("bus driven during read");
    a_write_drives_bus: assert property (@(posedge clock) disable iff (rst)
        !ctrl.write_n |-> display_data_bus_oe && $stable(display_data_bus_out))
        // [R8]
        else $error("write without stable data");
    a_setup_before_wr: assert property (@(posedge clock) disable iff (rst)
        $fell(ctrl.write_n) |-> $past(display_data_bus_oe, 2)) // [R4]
        else $error("write data setup too short");
    a_wr_low_width: assert property (@(posedge clock) disable iff (rst)
        $rose(ctrl.write_n) |-> wl_cnt_r >= C_WR_LOW) // [R6]
        else $error("write low pulse too short");
    a_rd_low_width: assert property (@(posedge clock) disable iff (rst)
        $fell(ctrl.read_n) |-> !ctrl.read_n [*6]) // [R10]
        else $error("read low pulse too short");
    a_rd_capture: assert property (@(posedge clock) disable iff (rst)
        $rose(ctrl.read_n) |-> rd_valid &&
        rd_data == $past(display_data_bus_in)) // [R5]
        else $error("read byte not captured");
    a_no_both_strobes: assert property (@(posedge clock) disable iff (rst)
        !(!ctrl.read_n && !ctrl.write_n)) // [R3]
        else $error("both strobes low");
    a_rs_stable: assert property (@(posedge clock) disable iff (rst)
        !ctrl.select_n && !$rose(ctrl.select_n) && $past(!ctrl.select_n)
        |-> $stable(ctrl.register_select)) // [R7]
        else $error("register select moved in access");
    a_oe_only_write: assert property (@(posedge clock) disable iff (rst)
        display_data_bus_oe |-> !cur_r.is_read && !ctrl.select_n) // [R1]
        else $error("bus driven outside write");
    a_reset_pulse: assert property (@(posedge clock) disable iff (rst)
        $fell(ctrl.display_reset_n) |-> !ctrl.display_reset_n [*8]) // [R9]
        else $error("display reset pulse too short");

    c_write: cover property (@(posedge clock) $rose(ctrl.write_n));
    c_read: cover property (@(posedge clock) rd_valid);
    c_reset: cover property (@(posedge clock) $rose(ctrl.display_reset_n));
    c_status: cover property (@(posedge clock)
        !ctrl.read_n && !ctrl.register_select);
endmodule
`default_nettype wire

// file: verif/display_model.sv
`timescale 1ns/100ps
`default_nettype none
// Display controller seen from its pins; no hold time kindness on reads
module display_model #(
    parameter logic [7:0] STATUS_BYTE = 8'hA5
) (
    input wire disp_bus_pkg::disp_ctrl_t ctrl,
    input wire logic [7:0] bus,
    output logic drive_en,
    output logic [7:0] drive_data
);
    logic [7:0] index_r;
    logic [7:0] ram_r [256];

    // Byte latched as the write strobe rises
    always @(posedge ctrl.write_n) begin
        if (!ctrl.select_n && ctrl.read_n) begin
            if (ctrl.register_select) begin
                ram_r[index_r] <= bus;
            end else begin
                index_r <= bus;
            end
        end
    end

    // Bus driven only during a selected read strobe
    assign drive_en = !ctrl.select_n && !ctrl.read_n && ctrl.write_n;
    assign drive_data = ctrl.register_select ? ram_r[index_r] : STATUS_BYTE;
endmodule
`default_nettype wire

// file: verif/display_parallel_bus_master_test.sv
`timescale 1ns/100ps
`default_nettype none
module display_parallel_bus_master_test;
    logic clock, rst, req_valid, reset_req, req_ready, rd_valid, oe, m_en;
    disp_bus_pkg::disp_req_t req;
    disp_bus_pkg::disp_ctrl_t ctrl;
    logic [7:0] rd_data, bus_out, bus, m_data;
    logic [7:0] last_bus_r = 8'h00;
    int num_errors, n_compared, cycles, wr_low, rd_low;

    display_parallel_bus_master display_parallel_bus_master_i (
        .clock(clock), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .reset_req(reset_req),
        .rd_valid(rd_valid), .rd_data(rd_data), .ctrl(ctrl),
        .display_data_bus_in(bus), .display_data_bus_out(bus_out),
        .display_data_bus_oe(oe));
    display_model display_model_i (
        .ctrl(ctrl), .bus(bus), .drive_en(m_en), .drive_data(m_data));

    // Released bus shows the inverse of the last driven byte, never a kind one
    assign bus = oe ? bus_out : (m_en ? m_data : ~last_bus_r);
    always @(posedge clock) begin
        if (oe || m_en) begin
            last_bus_r <= bus;
        end
    end

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cycle ceiling; a hang counts as a mismatch
    always @(negedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    // Pin watch at the falling edge, where outputs have settled
    always @(negedge clock) begin
        if (!ctrl.write_n) begin
            wr_low++;
            check(8'(oe), 8'h01);
            check(8'(ctrl.select_n), 8'h00);
        end else if (wr_low != 0) begin
            check(8'(wr_low), 8'(disp_bus_pkg::WR_LOW_CYC));
            wr_low = 0;
        end
        if (!ctrl.read_n) begin
            rd_low++;
            check(8'(oe), 8'h00);
            check(8'(ctrl.select_n), 8'h00);
        end else if (rd_low != 0) begin
            check(8'(rd_low), 8'(disp_bus_pkg::RD_LOW_CYC));
            rd_low = 0;
        end
    end

    // Entered just after an edge; holds the request up to its taking edge
    task automatic send(input logic rd, input logic rs, input logic [7:0] d);
        while (req_ready !== 1'b1) @(posedge clock) #1;
        req_valid = 1'b1;
        req = '{rd, rs, d};
        @(posedge clock) #1;
        req_valid = 1'b0;
    endtask

    task automatic read_expect(input logic rs, input logic [7:0] exp);
        send(1'b1, rs, 8'h00);
        while (rd_valid !== 1'b1) @(posedge clock) #1;
        check(rd_data, exp);
    endtask

    // Counts cycles with the display reset low
    task automatic reset_width;
        int n;
        n = 0;
        while (ctrl.display_reset_n === 1'b0) begin
            n++;
            @(posedge clock) #1;
        end
        check(8'(n), 8'(disp_bus_pkg::RST_LOW_CYC));
    endtask

    task automatic test_power_reset;
        check(8'(ctrl), 8'h1F);
        rst = 1'b0;
        @(posedge clock) #1;
        reset_width;
        $display("test_power_reset done");
    endtask

    // Index then data back to back, boundary bytes, then read back
    task automatic test_write_read;
        logic [7:0] vals [3];
        vals = '{8'h00, 8'hFF, 8'h81};
        foreach (vals[i]) begin
            send(1'b0, 1'b0, vals[i]);
            send(1'b0, 1'b1, ~vals[i]);
            read_expect(1'b0, 8'hA5);
            check(display_model_i.index_r, vals[i]);
            check(display_model_i.ram_r[vals[i]], ~vals[i]);
            read_expect(1'b1, ~vals[i]);
        end
        $display("test_write_read done");
    endtask

    task automatic test_reset_request;
        while (req_ready !== 1'b1) @(posedge clock) #1;
        reset_req = 1'b1;
        @(posedge clock) #1;
        reset_req = 1'b0;
        check(8'(req_ready), 8'h00);
        reset_width;
        $display("test_reset_request done");
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        reset_req = 1'b0;
        req = '0;
        repeat (12) @(posedge clock);
        #1;
        test_power_reset;
        test_write_read;
        test_reset_request;
        tally_and_finish;
    end
endmodule
`default_nettype wire
